/* inc/alarm_cfg_params.svh */
// Purpose: constants for the machine-side alarm and configuration block
// Assumes: 100 MHz clock, 8-bit register port
// Notes: offsets are register indices on the plain register port
`ifndef ALARM_CFG_PARAMS_SVH
`define ALARM_CFG_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_SAFETY 8'h00
`define OFF_MOTOR 8'h01
`define OFF_EXT 8'h02
`define OFF_LANG 8'h03
`define OFF_BAUD 8'h04
`define OFF_LUBE_RUN 8'h05
`define OFF_LUBE_GAP 8'h06
`define OFF_LOW_PRESSURE_INPUT_HOLD 8'h07
`define OFF_STATUS 8'h08

// ----------------------------------------
// field positions
// ----------------------------------------
`define SAF_HARD_MASK 6
`define SAF_DRV_MASK 5
`define SAF_MACH_MASK 4
`define SAF_TIP_MASK 3
`define SAF_GCODE_OK 2
`define SAF_HARD_HIGH 1
`define SAF_UPROG_OK 0
`define MOT_DIR_MSB 7
`define MOT_DIR_LSB 5
`define MOT_DRV_MSB 4
`define MOT_DRV_LSB 2
`define MOT_Y_EN 1
`define MOT_EXP 0
`define EXT_START_EN 7
`define EXT_HOLD_EN 6
`define EXT_LOW_PRESSURE_INPUT_EN 5
`define EXT_LOW_PRESSURE_INPUT_LOW 4
`define EXT_RESET_CMD 2
`define EXT_ESTOP_CMD 1
`define EXT_PIN_ALL 0
`define LANG_RADIUS 6
`define BAUD_SEL_19200 7
`define BAUD_SEL_38400 6
`define STAT_LOW_PRESSURE_INPUT_CLR 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CFG 8'h00
`define RST_LUBE_RUN 8'h05
`define RST_LUBE_GAP 8'h3C
`define RST_LOW_PRESSURE_INPUT_HOLD 8'h03
`define PIN_IDLE_HARD 1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS 10
`define SECOND_NS 1000000000
`define BAUD_A 9600
`define BAUD_B 19200
`define BAUD_C 38400
`define SEC_CYCLES (`SECOND_NS / `CLK_NS)
`define BAUD_CYCLES(b) (`SECOND_NS / (`CLK_NS * (b)))
`define DIV_W 27
`define CNT_W 9

`endif

/* inc/alarm_cfg_pkg.sv */
// Purpose: types shared by the alarm and configuration block
// Assumes: nothing beyond the parameter header
// Notes: state of each module is one packed struct
package alarm_cfg_pkg;

  typedef struct packed {
    logic hard_limit;
    logic [2:0] drive;
    logic low_pressure;
    logic ext_start;
    logic ext_pause;
    logic hold_knob;
  } pins_t;

  typedef struct packed {
    logic [7:0] safety;
    logic [7:0] motor;
    logic [7:0] ext;
    logic [7:0] lang;
    logic [7:0] baud;
    logic [7:0] lube_run;
    logic [7:0] lube_gap;
    logic [7:0] low_pressure_input_hold;
  } cfg_t;

  typedef enum logic [1:0] {LUBE_GAP = 2'b01, LUBE_RUN = 2'b10} lube_t;

  typedef struct packed {
    logic ack;
    logic nak;
  } verdict_t;

  typedef struct packed {
    verdict_t y_move;
    verdict_t pin_set;
    verdict_t uprog;
    verdict_t gcode;
  } answers_t;

endpackage

/* hw/sync2.sv */
// Purpose: two-stage synchroniser for the machine input pins
// Assumes: pins may change at any time
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
`include "alarm_cfg_params.svh"
module sync2
  import alarm_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire pins_t d,
  output pins_t q
);
  typedef struct packed {
    pins_t meta;
    pins_t stable;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      // low-active limit switch idles high: no false alarm after reset
      s_q.meta.hard_limit <= `PIN_IDLE_HARD;
      s_q.stable.hard_limit <= `PIN_IDLE_HARD;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;
endmodule // sync2
`default_nettype wire

/* hw/tick_div.sv */
// Purpose: reloadable divider giving a one-cycle enable pulse
// Assumes: load value of at least one
// Notes: a new load value takes effect at the next reload
`timescale 1ns/1ps
`default_nettype none
`include "alarm_cfg_params.svh"
module tick_div
  import alarm_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`DIV_W-1:0] load,
  output logic tick
);
  typedef struct packed {
    logic [`DIV_W-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt <= `DIV_W'(1)) begin
      s_d.cnt = load;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt - `DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule // tick_div
`default_nettype wire

/* hw/alarm_cfg.sv */
// Purpose: alarm masking, input polarity, axis options, pressure and lube timing
// Assumes: register port with read data one cycle after the read strobe
// Notes: all request answers are one-cycle pulses one cycle after the request
`timescale 1ns/1ps
`default_nettype none
`include "alarm_cfg_params.svh"
module alarm_cfg
  import alarm_cfg_pkg::*;
#(
  parameter int SEC_CYCLES = `SEC_CYCLES,
  parameter int BAUD_A_CYCLES = `BAUD_CYCLES(`BAUD_A),
  parameter int BAUD_B_CYCLES = `BAUD_CYCLES(`BAUD_B),
  parameter int BAUD_C_CYCLES = `BAUD_CYCLES(`BAUD_C)
)
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire pins_t PINS,
  input wire logic SOFT_MACH_IN,
  input wire logic SOFT_TIP_IN,
  input wire logic [2:0] DIR_IN,
  input wire logic Y_MOVE_REQ,
  input wire logic PIN_SET_REQ,
  input wire logic PIN_IS_DEDICATED,
  input wire logic UPROG_WR_REQ,
  input wire logic GCODE_REQ,
  input wire logic GCODE_IS_DWELL,
  input wire logic STD_RESET_DONE,
  input wire logic STD_ESTOP_DONE,
  input wire logic MAN_AUTO_MODE,
  output logic HARD_LIMIT_ALARM,
  output logic [2:0] DRIVE_ALARM,
  output logic [1:0] SOFT_LIMIT_ALARM,
  output logic [2:0] DIR_OUT,
  output logic ACCEL_EXP,
  output logic RADIUS_MODE,
  output logic EXT_START,
  output logic EXT_PAUSE,
  output logic FEED_HOLD,
  output logic LOW_PRESSURE_ALARM,
  output logic FEED_PAUSE,
  output logic SPINDLE_STOP,
  output logic CYCLE_START_BLOCK,
  output logic RUN_RESET_CMD,
  output logic RUN_ESTOP_CMD,
  output answers_t ANSWERS,
  output logic LUBE_ON,
  output logic BAUD_TICK
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    cfg_t cfg;
    logic [7:0] rdata;
    logic [`CNT_W-1:0] low_pressure_input_cnt;
    logic low_pressure_input_alarm;
    lube_t lube;
    logic [`CNT_W-1:0] lube_cnt;
    logic lube_on;
    logic hard_alarm;
    logic [2:0] drive_alarm;
    logic [1:0] soft_alarm;
    logic [2:0] dir;
    logic ext_start;
    logic ext_pause;
    logic feed_hold;
    logic run_reset;
    logic run_estop;
    answers_t ans;
  } state_t;

  state_t s_q;
  state_t s_d;
  pins_t pins_s;
  logic sec_tick;
  logic baud_tick;
  logic [`DIV_W-1:0] baud_load;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // ack and nak are exclusive by construction
  function automatic verdict_t judge(input logic req, input logic ok);
    judge.ack = req & ok;
    judge.nak = req & ~ok;
  endfunction

  // saturating count on a seconds tick
  function automatic logic [`CNT_W-1:0] bump(input logic [`CNT_W-1:0] c, input logic t);
    bump = (t && c != '1) ? c + `CNT_W'(1) : c;
  endfunction

  function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] a);
    reg_read = 8'h00;
    case (a)
      `OFF_SAFETY: reg_read = s.cfg.safety;
      `OFF_MOTOR: reg_read = s.cfg.motor;
      `OFF_EXT: reg_read = s.cfg.ext;
      `OFF_LANG: reg_read = s.cfg.lang;
      `OFF_BAUD: reg_read = s.cfg.baud;
      `OFF_LUBE_RUN: reg_read = s.cfg.lube_run;
      `OFF_LUBE_GAP: reg_read = s.cfg.lube_gap;
      `OFF_LOW_PRESSURE_INPUT_HOLD: reg_read = s.cfg.low_pressure_input_hold;
      `OFF_STATUS: reg_read = {s.lube_on, s.soft_alarm, s.drive_alarm, s.hard_alarm,
                               s.low_pressure_input_alarm};
      default: reg_read = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // input conditioning and dividers
  // ----------------------------------------
  sync2 u_sync (
    .clk(MCLK),
    .rst_n(RSTN),
    .d(PINS),
    .q(pins_s)
  );

  // ----------------------------------------
  // seconds base
  // ----------------------------------------
  tick_div u_sec (
    .clk(MCLK),
    .rst_n(RSTN),
    .load(`DIV_W'(SEC_CYCLES)),
    .tick(sec_tick)
  );

  // ----------------------------------------
  // baud rate
  // ----------------------------------------
  // 38400 overrides the d7 choice
  assign baud_load = s_q.cfg.baud[`BAUD_SEL_38400] ? `DIV_W'(BAUD_C_CYCLES) :
                     s_q.cfg.baud[`BAUD_SEL_19200] ? `DIV_W'(BAUD_B_CYCLES) :
                     `DIV_W'(BAUD_A_CYCLES);

  tick_div u_baud (
    .clk(MCLK),
    .rst_n(RSTN),
    .load(baud_load),
    .tick(baud_tick)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic low_pressure_input_on;
    logic low_pressure_input_set;
    logic low_pressure_input_clr;
    logic [2:0] drv_hit;
    logic hard_hit;
    s_d = s_q;
    low_pressure_input_on = 1'b0;
    low_pressure_input_set = 1'b0;
    low_pressure_input_clr = 1'b0;
    drv_hit = 3'h0;
    hard_hit = 1'b0;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (REG_WR) begin
      case (REG_ADDR)
        `OFF_SAFETY: s_d.cfg.safety = REG_WDATA;
        `OFF_MOTOR: s_d.cfg.motor = REG_WDATA;
        `OFF_EXT: s_d.cfg.ext = REG_WDATA;
        `OFF_LANG: s_d.cfg.lang = REG_WDATA;
        `OFF_BAUD: s_d.cfg.baud = REG_WDATA;
        `OFF_LUBE_RUN: s_d.cfg.lube_run = REG_WDATA;
        `OFF_LUBE_GAP: s_d.cfg.lube_gap = REG_WDATA;
        `OFF_LOW_PRESSURE_INPUT_HOLD: s_d.cfg.low_pressure_input_hold = REG_WDATA;
        `OFF_STATUS: low_pressure_input_clr = REG_WDATA[`STAT_LOW_PRESSURE_INPUT_CLR];
        default: ;
      endcase
    end
    // read data valid only in the cycle after the strobe
    s_d.rdata = REG_RD ? reg_read(s_q, REG_ADDR) : 8'h00;

    // ----------------------------------------
    // alarm inputs
    // ----------------------------------------
    // hard limit: level select then mask
    hard_hit = s_q.cfg.safety[`SAF_HARD_HIGH] ? pins_s.hard_limit
                                             : ~pins_s.hard_limit;
    s_d.hard_alarm = hard_hit & ~s_q.cfg.safety[`SAF_HARD_MASK];

    // drive alarm: 0 means high is alarm, 1 means low is alarm
    drv_hit = pins_s.drive ^ s_q.cfg.motor[`MOT_DRV_MSB:`MOT_DRV_LSB];
    s_d.drive_alarm = s_q.cfg.safety[`SAF_DRV_MASK] ? 3'h0 : drv_hit;

    s_d.soft_alarm = {SOFT_MACH_IN & ~s_q.cfg.safety[`SAF_MACH_MASK],
                      SOFT_TIP_IN & ~s_q.cfg.safety[`SAF_TIP_MASK]};

    s_d.dir = DIR_IN ^ s_q.cfg.motor[`MOT_DIR_MSB:`MOT_DIR_LSB];

    // ----------------------------------------
    // operator panel
    // ----------------------------------------
    // external operator inputs; start held off during a pressure alarm
    s_d.ext_start = pins_s.ext_start & s_q.cfg.ext[`EXT_START_EN] & ~s_q.low_pressure_input_alarm;
    s_d.ext_pause = pins_s.ext_pause & s_q.cfg.ext[`EXT_START_EN];
    s_d.feed_hold = pins_s.hold_knob & s_q.cfg.ext[`EXT_HOLD_EN];

    // ----------------------------------------
    // low pressure hold timer
    // ----------------------------------------
    low_pressure_input_on = s_q.cfg.ext[`EXT_LOW_PRESSURE_INPUT_LOW] ? ~pins_s.low_pressure
                                         : pins_s.low_pressure;
    // count saturates, so a long hold cannot wrap below the limit
    if (!s_q.cfg.ext[`EXT_LOW_PRESSURE_INPUT_EN]) begin
      s_d.low_pressure_input_cnt = '0;
      s_d.low_pressure_input_alarm = 1'b0;
    end else begin
      s_d.low_pressure_input_cnt = low_pressure_input_on ? bump(s_q.low_pressure_input_cnt, sec_tick) : '0;
      // whole seconds held must exceed the hold time
      low_pressure_input_set = low_pressure_input_on && (s_q.low_pressure_input_cnt > {1'b0, s_q.cfg.low_pressure_input_hold});
      // a new event in the clearing cycle wins
      s_d.low_pressure_input_alarm = low_pressure_input_set | (s_q.low_pressure_input_alarm & ~low_pressure_input_clr);
    end

    // ----------------------------------------
    // lubrication cycle
    // ----------------------------------------
    // a zero run time parks the pump in the interval phase
    s_d.lube_cnt = bump(s_q.lube_cnt, sec_tick);
    unique case (s_q.lube)
      LUBE_GAP: begin
        s_d.lube_on = 1'b0;
        if (s_q.lube_cnt >= {1'b0, s_q.cfg.lube_gap} && s_q.cfg.lube_run != 8'h00) begin
          s_d.lube = LUBE_RUN;
          s_d.lube_cnt = '0;
          s_d.lube_on = 1'b1;
        end
      end
      LUBE_RUN: begin
        s_d.lube_on = 1'b1;
        if (s_q.lube_cnt >= {1'b0, s_q.cfg.lube_run}) begin
          s_d.lube = LUBE_GAP;
          s_d.lube_cnt = '0;
          s_d.lube_on = 1'b0;
        end
      end
      default: begin
        // illegal code recovers into the interval phase
        s_d.lube = LUBE_GAP;
        s_d.lube_cnt = '0;
        s_d.lube_on = 1'b0;
      end
    endcase

    // ----------------------------------------
    // user command hooks and request answers
    // ----------------------------------------
    s_d.run_reset = STD_RESET_DONE & MAN_AUTO_MODE & s_q.cfg.ext[`EXT_RESET_CMD];
    s_d.run_estop = STD_ESTOP_DONE & MAN_AUTO_MODE & s_q.cfg.ext[`EXT_ESTOP_CMD];
    // every request gets exactly one answer pulse
    s_d.ans.y_move = judge(Y_MOVE_REQ, s_q.cfg.motor[`MOT_Y_EN]);
    s_d.ans.pin_set = judge(PIN_SET_REQ,
                            ~PIN_IS_DEDICATED | s_q.cfg.ext[`EXT_PIN_ALL]);
    s_d.ans.uprog = judge(UPROG_WR_REQ, s_q.cfg.safety[`SAF_UPROG_OK]);
    s_d.ans.gcode = judge(GCODE_REQ,
                          GCODE_IS_DWELL | s_q.cfg.safety[`SAF_GCODE_OK]);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      // settings return to their defaults on every reset
      s_q <= '0;
      s_q.cfg.safety <= `RST_CFG;
      s_q.cfg.motor <= `RST_CFG;
      s_q.cfg.ext <= `RST_CFG;
      s_q.cfg.lang <= `RST_CFG;
      s_q.cfg.baud <= `RST_CFG;
      s_q.cfg.lube_run <= `RST_LUBE_RUN;
      s_q.cfg.lube_gap <= `RST_LUBE_GAP;
      s_q.cfg.low_pressure_input_hold <= `RST_LOW_PRESSURE_INPUT_HOLD;
      s_q.lube <= LUBE_GAP;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign REG_RDATA = s_q.rdata;
  assign HARD_LIMIT_ALARM = s_q.hard_alarm;
  assign DRIVE_ALARM = s_q.drive_alarm;
  assign SOFT_LIMIT_ALARM = s_q.soft_alarm;
  assign DIR_OUT = s_q.dir;
  assign ACCEL_EXP = s_q.cfg.motor[`MOT_EXP];
  assign RADIUS_MODE = s_q.cfg.lang[`LANG_RADIUS];
  assign EXT_START = s_q.ext_start;
  assign EXT_PAUSE = s_q.ext_pause;
  assign FEED_HOLD = s_q.feed_hold;
  assign LOW_PRESSURE_ALARM = s_q.low_pressure_input_alarm;
  assign FEED_PAUSE = s_q.low_pressure_input_alarm;
  assign SPINDLE_STOP = s_q.low_pressure_input_alarm;
  assign CYCLE_START_BLOCK = s_q.low_pressure_input_alarm;
  assign RUN_RESET_CMD = s_q.run_reset;
  assign RUN_ESTOP_CMD = s_q.run_estop;
  assign ANSWERS = s_q.ans;
  assign LUBE_ON = s_q.lube_on;
  assign BAUD_TICK = baud_tick;

endmodule // alarm_cfg
`default_nettype wire

/* bench/alarm_cfg_sva.sv */
// Purpose: port-level checks for alarm_cfg
// Assumes: config shadowed from register writes
// Notes: pin paths checked only where masked
`timescale 1ns/1ps
`default_nettype none
`include "alarm_cfg_params.svh"
module alarm_cfg_sva
  import alarm_cfg_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic [2:0] DIR_IN,
  input wire logic Y_MOVE_REQ,
  input wire logic GCODE_REQ,
  input wire logic GCODE_IS_DWELL,
  input wire logic STD_RESET_DONE,
  input wire logic MAN_AUTO_MODE,
  input wire logic RUN_RESET_CMD,
  input wire logic HARD_LIMIT_ALARM,
  input wire logic [2:0] DRIVE_ALARM,
  input wire logic [2:0] DIR_OUT,
  input wire logic ACCEL_EXP,
  input wire logic LOW_PRESSURE_ALARM,
  input wire answers_t ANSWERS
);
  // ----
  // config shadow
  // ----
  logic [7:0] saf_q, mot_q, ext_q;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      saf_q <= `RST_CFG;
      mot_q <= `RST_CFG;
      ext_q <= `RST_CFG;
    end else if (REG_WR) begin
      if (REG_ADDR == `OFF_SAFETY) saf_q <= REG_WDATA;
      if (REG_ADDR == `OFF_MOTOR) mot_q <= REG_WDATA;
      if (REG_ADDR == `OFF_EXT) ext_q <= REG_WDATA;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // ----
  // checks
  // ----
  dir_invert_a: assert property ($past(RSTN) |-> DIR_OUT == $past(DIR_IN ^ mot_q[7:5]))
    else $error("direction output wrong");
  // ramp select is a register bit, so it tracks every motor write at once
  accel_sel_a: assert property (ACCEL_EXP == mot_q[0])
    else $error("ramp select wrong");
  y_move_a: assert property (Y_MOVE_REQ |=>
    ANSWERS.y_move == ($past(mot_q[1]) ? 2'b10 : 2'b01)) else $error("y move answer wrong");
  gcode_answer_a: assert property (GCODE_REQ |=> ANSWERS.gcode ==
    (($past(GCODE_IS_DWELL) || $past(saf_q[2])) ? 2'b10 : 2'b01)) else $error("gcode answer wrong");
  reset_hook_a: assert property (STD_RESET_DONE && MAN_AUTO_MODE |=>
    RUN_RESET_CMD == $past(ext_q[2])) else $error("reset hook wrong");
  hard_mask_a: assert property (saf_q[6] && $past(saf_q[6]) |-> !HARD_LIMIT_ALARM)
    else $error("masked hard limit raised");
  drive_mask_a: assert property (saf_q[5] && $past(saf_q[5]) |-> DRIVE_ALARM == 3'h0)
    else $error("masked drive alarm raised");
  low_pressure_input_off_a: assert property (!ext_q[5] && !$past(ext_q[5]) |-> !LOW_PRESSURE_ALARM)
    else $error("pressure alarm while disabled");
endmodule // alarm_cfg_sva
bind alarm_cfg alarm_cfg_sva u_alarm_cfg_sva (.MCLK, .RSTN, .REG_ADDR, .REG_WDATA, .REG_WR,
  .DIR_IN, .Y_MOVE_REQ, .GCODE_REQ, .GCODE_IS_DWELL, .STD_RESET_DONE, .MAN_AUTO_MODE,
  .RUN_RESET_CMD, .HARD_LIMIT_ALARM, .DRIVE_ALARM, .DIR_OUT, .ACCEL_EXP, .LOW_PRESSURE_ALARM,
  .ANSWERS);
`default_nettype wire

/* bench/machine_model.sv */
// Purpose: machine wiring: limit switch, drives, pressure switch, panel
// Assumes: wiring polarity follows the controller settings
// Notes: plain levels, no bounce
`timescale 1ns/1ps
`default_nettype none
module machine_model
  import alarm_cfg_pkg::*;
(
  input wire logic hard_on,
  input wire logic hard_high,
  input wire logic [2:0] drv_on,
  input wire logic [2:0] drv_low,
  input wire logic low_pressure_input_on,
  input wire logic low_pressure_input_low,
  input wire logic [2:0] panel,
  output pins_t pins
);
  assign pins.hard_limit = hard_on ~^ hard_high;
  assign pins.drive = drv_on ^ drv_low;
  assign pins.low_pressure = low_pressure_input_on ^ low_pressure_input_low;
  assign {pins.ext_start, pins.ext_pause, pins.hold_knob} = panel;
endmodule // machine_model
`default_nettype wire

/* bench/alarm_cfg_test.sv */
// Purpose: self-checking bench for alarm_cfg
// Assumes: a second shortened to 20 cycles
// Notes: expectations follow the settings written
`timescale 1ns/1ps
`default_nettype none
`include "alarm_cfg_params.svh"
module alarm_cfg_test
  import alarm_cfg_pkg::*;
;
  // ----
  // signals
  // ----
  logic MCLK = 1'b0, RSTN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  pins_t PINS;
  logic SOFT_MACH_IN = 1'b0, SOFT_TIP_IN = 1'b0, PIN_IS_DEDICATED = 1'b1;
  logic GCODE_IS_DWELL = 1'b0, STD_RESET_DONE = 1'b0, STD_ESTOP_DONE = 1'b0;
  logic MAN_AUTO_MODE = 1'b1, hard_on = 1'b0, low_pressure_input_on = 1'b0;
  logic [2:0] DIR_IN = 3'h0, drv_on = 3'h0, panel = 3'h0, DRIVE_ALARM, DIR_OUT;
  logic [3:0] req = 4'h0;
  logic HARD_LIMIT_ALARM, ACCEL_EXP, RADIUS_MODE, EXT_START, EXT_PAUSE, FEED_HOLD;
  logic LOW_PRESSURE_ALARM, FEED_PAUSE, SPINDLE_STOP, CYCLE_START_BLOCK;
  logic RUN_RESET_CMD, RUN_ESTOP_CMD, LUBE_ON, BAUD_TICK;
  logic [1:0] SOFT_LIMIT_ALARM;
  answers_t ANSWERS;
  logic [7:0] saf = 8'h00, mot = 8'h00, ext = 8'h00, n;
  logic [7:0] rv [9] = '{`RST_CFG, `RST_CFG, `RST_CFG, `RST_CFG, `RST_CFG,
    `RST_LUBE_RUN, `RST_LUBE_GAP, `RST_LOW_PRESSURE_INPUT_HOLD, 8'h00};
  int per [4] = '{8, 2, 4, 2};
  int num_errors = 0;
  int tests_run = 0;
  alarm_cfg #(.SEC_CYCLES(20), .BAUD_A_CYCLES(8), .BAUD_B_CYCLES(4), .BAUD_C_CYCLES(2))
  u_alarm_cfg (.MCLK, .RSTN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .PINS,
    .SOFT_MACH_IN, .SOFT_TIP_IN, .DIR_IN, .Y_MOVE_REQ(req[3]), .PIN_SET_REQ(req[2]),
    .PIN_IS_DEDICATED, .UPROG_WR_REQ(req[1]), .GCODE_REQ(req[0]), .GCODE_IS_DWELL,
    .STD_RESET_DONE, .STD_ESTOP_DONE, .MAN_AUTO_MODE, .HARD_LIMIT_ALARM, .DRIVE_ALARM,
    .SOFT_LIMIT_ALARM, .DIR_OUT, .ACCEL_EXP, .RADIUS_MODE, .EXT_START, .EXT_PAUSE,
    .FEED_HOLD, .LOW_PRESSURE_ALARM, .FEED_PAUSE, .SPINDLE_STOP, .CYCLE_START_BLOCK,
    .RUN_RESET_CMD, .RUN_ESTOP_CMD, .ANSWERS, .LUBE_ON, .BAUD_TICK);
  machine_model u_machine_model (.hard_on, .hard_high(saf[1]), .drv_on, .drv_low(mot[4:2]),
    .low_pressure_input_on, .low_pressure_input_low(ext[4]), .panel, .pins(PINS));
  initial begin
    forever #5 MCLK = ~MCLK;
  end
  // ----
  // tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge MCLK);
    #1;
  endtask
  // shadows move by nonblocking so pins never race the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
    if (a == `OFF_SAFETY) saf <= d;
    if (a == `OFF_MOTOR) mot <= d;
    if (a == `OFF_EXT) ext <= d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, e);
  endtask
  task automatic ask(input int i, input logic [1:0] e);
    logic [7:0] a;
    @(posedge MCLK);
    req[i] <= 1'b1;
    @(posedge MCLK);
    req <= 4'h0;
    #1 a = ANSWERS;
    chk(a[2*i+:2], e);
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    num_errors++;
    test_done();
  end
  // ----
  // sequence
  // ----
  initial begin
    repeat (16) @(posedge MCLK);
    RSTN <= 1'b1;
    for (int k = 0; k < 9; k++) rd(k[7:0], rv[k]);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    wr(`OFF_LANG, 8'h40);
    rd(`OFF_LANG, 8'h40);
    settle(2);
    chk(RADIUS_MODE, 1'b1);
    wr(`OFF_MOTOR, 8'hE1);
    DIR_IN <= 3'h5;
    settle(2);
    chk(DIR_OUT, 3'h2);
    chk(ACCEL_EXP, 1'b1);
    wr(`OFF_MOTOR, 8'h00);
    for (int i = 0; i < 4; i++) ask(i, 2'b01);
    @(posedge MCLK);
    GCODE_IS_DWELL <= 1'b1;
    ask(0, 2'b10);
    wr(`OFF_SAFETY, 8'h05);
    wr(`OFF_MOTOR, 8'h02);
    wr(`OFF_EXT, 8'h01);
    GCODE_IS_DWELL <= 1'b0;
    for (int i = 0; i < 4; i++) ask(i, 2'b10);
    @(posedge MCLK);
    hard_on <= 1'b1;
    settle(2);
    chk(HARD_LIMIT_ALARM, 1'b0);
    settle(1);
    chk(HARD_LIMIT_ALARM, 1'b1);
    wr(`OFF_SAFETY, 8'h45);
    settle(2);
    chk(HARD_LIMIT_ALARM, 1'b0);
    wr(`OFF_SAFETY, 8'h07);
    settle(4);
    chk(HARD_LIMIT_ALARM, 1'b1);
    @(posedge MCLK);
    hard_on <= 1'b0;
    drv_on <= 3'h2;
    settle(4);
    chk(DRIVE_ALARM, 3'h2);
    wr(`OFF_MOTOR, 8'h1E);
    settle(4);
    chk(DRIVE_ALARM, 3'h2);
    wr(`OFF_SAFETY, 8'h27);
    settle(2);
    chk(DRIVE_ALARM, 3'h0);
    @(posedge MCLK);
    drv_on <= 3'h0;
    SOFT_MACH_IN <= 1'b1;
    SOFT_TIP_IN <= 1'b1;
    settle(2);
    chk(SOFT_LIMIT_ALARM, 2'b11);
    wr(`OFF_SAFETY, 8'h3F);
    settle(2);
    chk(SOFT_LIMIT_ALARM, 2'b00);
    @(posedge MCLK);
    SOFT_MACH_IN <= 1'b0;
    SOFT_TIP_IN <= 1'b0;
    panel <= 3'h7;
    settle(4);
    chk({EXT_START, EXT_PAUSE, FEED_HOLD}, 3'h0);
    wr(`OFF_EXT, 8'hC1);
    settle(2);
    chk({EXT_START, EXT_PAUSE, FEED_HOLD}, 3'h7);
    @(posedge MCLK);
    panel <= 3'h0;
    wr(`OFF_LOW_PRESSURE_INPUT_HOLD, 8'h01);
    wr(`OFF_EXT, 8'h30);
    low_pressure_input_on <= 1'b1;
    settle(18);
    chk(LOW_PRESSURE_ALARM, 1'b0);
    for (int k = 0; k < 40 && LOW_PRESSURE_ALARM !== 1'b1; k++) settle(1);
    chk({LOW_PRESSURE_ALARM, FEED_PAUSE, SPINDLE_STOP, CYCLE_START_BLOCK}, 4'hF);
    @(posedge MCLK);
    low_pressure_input_on <= 1'b0;
    settle(4);
    chk(LOW_PRESSURE_ALARM, 1'b1);
    wr(`OFF_STATUS, 8'h01);
    settle(2);
    chk(LOW_PRESSURE_ALARM, 1'b0);
    wr(`OFF_EXT, 8'h20);
    low_pressure_input_on <= 1'b1;
    for (int k = 0; k < 60 && LOW_PRESSURE_ALARM !== 1'b1; k++) settle(1);
    chk(LOW_PRESSURE_ALARM, 1'b1);
    wr(`OFF_EXT, 8'h10);
    low_pressure_input_on <= 1'b1;
    settle(60);
    chk(LOW_PRESSURE_ALARM, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(`OFF_EXT, {5'h00, k[0], k[0], 1'b0});
      low_pressure_input_on <= 1'b0;
      @(posedge MCLK);
      STD_RESET_DONE <= 1'b1;
      STD_ESTOP_DONE <= 1'b1;
      @(posedge MCLK);
      STD_RESET_DONE <= 1'b0;
      STD_ESTOP_DONE <= 1'b0;
      #1 chk({RUN_RESET_CMD, RUN_ESTOP_CMD}, {2{k[0]}});
    end
    wr(`OFF_LUBE_GAP, 8'h01);
    wr(`OFF_LUBE_RUN, 8'h01);
    for (int k = 0; k < 60 && LUBE_ON !== 1'b1; k++) settle(1);
    chk(LUBE_ON, 1'b1);
    for (int k = 0; k < 40 && LUBE_ON !== 1'b0; k++) settle(1);
    chk(LUBE_ON, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(`OFF_BAUD, {k[1:0], 6'h00});
      settle(10);
      n = 8'h00;
      repeat (16) begin
        settle(1);
        n = n + {7'h00, BAUD_TICK};
      end
      chk(n, 8'(16 / per[k]));
    end
    test_done();
  end
endmodule // alarm_cfg_test
`default_nettype wire
